/* hdl/scrc_core.sv */
// Overview of operation
// - Hold clear: brightness settings apply at frame boundary
// - Hold set: frame-synced settings frozen until cleared
// - Bad frame with restart bit forces readout restart
// - Show-bad clear: bad frames masked at output
// - Show-bad set: bad frames are output too
// - Processor-reset bit drives downstream reset directly
// - Output-disable bit drives video_oe low; all outputs stay driven
// - Readout enable zero stops; rising restarts frame
// - Analog standby disables analog; software clears readout
// - Restart bit abandons frame, waits one integration
// - Restart bit self-clears and always reads zero
// - Soft reset holds timing and frame-synced settings at power-up defaults
// - Horizontal blanking never below mode minimum
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module scrc_core (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire scrc_pkg::scrc_req_s bus_req,
    output logic [scrc_pkg::DATA_W-1:0] rdata,
    // Readout mode pin
    input wire logic low_power_mode,
    // Video timing outputs
    output logic fv_out,
    output logic lv_out,
    output logic video_oe,
    // Side controls
    output logic proc_reset,
    output logic analog_en,
    output logic sensor_reset
);
    import scrc_pkg::*;

    scrc_core_s state;
    scrc_core_s next_state;

    // ------------------------------------------------------------
    // Decoded control fields
    // ------------------------------------------------------------
    logic hold;
    logic restart_bad;
    logic show_bad;
    logic readout_en;
    logic soft_rst;

    assign hold = state.ctl[BIT_HOLD];
    assign restart_bad = state.ctl[BIT_RESTART_BAD];
    assign show_bad = state.ctl[BIT_SHOW_BAD];
    assign readout_en = state.ctl[BIT_READOUT_EN];
    assign soft_rst = state.ctl[BIT_SOFT_RESET];

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    logic wr_ctl;
    logic wr_hblank;
    logic wr_shutter;
    logic restart_wr;

    function automatic logic reg_hit(input logic strobe, input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] index);
        return strobe && (addr == index);
    endfunction

    assign wr_ctl = reg_hit(bus_req.wr, bus_req.addr, ADDR_CTRL);
    assign wr_hblank = reg_hit(bus_req.wr, bus_req.addr, ADDR_HBLANK);
    assign wr_shutter = reg_hit(bus_req.wr, bus_req.addr, ADDR_SHUTTER);
    assign restart_wr = wr_ctl && bus_req.wdata[BIT_RESTART];

    // ------------------------------------------------------------
    // Frame synchronised settings
    // ------------------------------------------------------------
    logic frame_last;
    logic row_end;
    logic apply;
    logic [HBLANK_W-1:0] hb_staged;
    logic [HBLANK_W-1:0] hb_active;
    logic hb_changed;
    logic [SHUTTER_W-1:0] sh_staged;
    logic [SHUTTER_W-1:0] sh_active;

    assign apply = frame_last && !hold && !soft_rst;

    scrc_shadow #(
        .W(HBLANK_W),
        .RESET(HBLANK_RESET)
    ) u_hblank (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clr(soft_rst),
        .wr(wr_hblank),
        .wdata(bus_req.wdata[HBLANK_W-1:0]),
        .apply(apply),
        .staged(hb_staged),
        .active(hb_active),
        .changed(hb_changed)
    );

    scrc_shadow #(
        .W(SHUTTER_W),
        .RESET(SHUTTER_RESET)
    ) u_shutter (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clr(soft_rst),
        .wr(wr_shutter),
        .wdata(bus_req.wdata),
        .apply(apply),
        .staged(sh_staged),
        .active(sh_active),
        .changed()
    );

    // ------------------------------------------------------------
    // Effective horizontal blanking
    // ------------------------------------------------------------
    logic [HBLANK_W-1:0] hb_min;
    logic [HBLANK_W-1:0] hb_eff;

    assign hb_min = state.lp_sync ? HBLANK_MIN_LOW : HBLANK_MIN_FULL;
    assign hb_eff = (hb_active < hb_min) ? hb_min : hb_active;

    // ------------------------------------------------------------
    // Readout timing
    // ------------------------------------------------------------
    logic t_lv;
    logic t_fv;
    logic t_run;

    assign t_run = readout_en && !soft_rst;

    scrc_frame_timer u_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(t_run),
        .restart(state.restart_req || soft_rst),
        .hblank(hb_eff),
        .lv(t_lv),
        .fv(t_fv),
        .row_end(row_end),
        .frame_last(frame_last)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic show;
    logic bad_restart;

    always_comb begin
        next_state = state;
        next_state.restart_req = 1'b0;
        next_state.rdata = '0;
        bad_restart = 1'b0;

        // Low power pin synchroniser
        next_state.lp_meta = low_power_mode;
        next_state.lp_sync = state.lp_meta;

        // Control register store
        if (wr_ctl) begin
            next_state.ctl = bus_req.wdata & CTRL_MASK;
        end

        // Readback
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                ADDR_CTRL: next_state.rdata = state.ctl & CTRL_MASK;
                ADDR_HBLANK: next_state.rdata = DATA_W'(hb_staged);
                ADDR_SHUTTER: next_state.rdata = sh_staged;
                default: next_state.rdata = '0;
            endcase
        end

        // Readout enable edge
        next_state.en_prev = readout_en;

        if (soft_rst) begin
            next_state.bad_cur = 1'b0;
            next_state.gate = 1'b1;
            next_state.integ = '0;
        end else begin
            // Integration wait counts rows; its end starts a fresh frame
            if (row_end && (state.integ != '0)) begin
                next_state.integ = state.integ - 16'h0001;
                if (state.integ == 16'h0001) begin
                    next_state.restart_req = 1'b1;
                    next_state.gate = 1'b1;
                end
            end
            // Frame boundary: judge next frame
            if (frame_last) begin
                next_state.bad_cur = 1'b0;
                next_state.gate = (next_state.integ == '0);
            end
            // First frame after a geometry change is bad
            if (hb_changed) begin
                next_state.bad_cur = 1'b1;
                bad_restart = restart_bad;
            end
            // Restart sources
            if (restart_wr || bad_restart || (readout_en && !state.en_prev)) begin
                next_state.restart_req = 1'b1;
                next_state.integ = sh_active;
                next_state.gate = (sh_active == '0);
                next_state.bad_cur = 1'b0;
            end
        end

        // Output stage
        show = show_bad || !next_state.bad_cur;
        // Counters still show the old frame while a restart lands
        next_state.fv = t_fv && next_state.gate && show && !soft_rst && !state.restart_req;
        next_state.lv = t_lv && next_state.gate && show && !soft_rst && !state.restart_req;
        next_state.oe = !next_state.ctl[BIT_OUT_DISABLE];
        next_state.proc_rst = next_state.ctl[BIT_PROC_RESET];
        next_state.analog_en = !next_state.ctl[BIT_STANDBY];
        next_state.sensor_rst = next_state.ctl[BIT_SOFT_RESET];
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
            state.ctl <= CTRL_RESET;
            state.en_prev <= 1'b1;
            state.gate <= 1'b1;
            state.oe <= 1'b1;
            state.analog_en <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata = state.rdata;
    assign fv_out = state.fv;
    assign lv_out = state.lv;
    assign video_oe = state.oe;
    assign proc_reset = state.proc_rst;
    assign analog_en = state.analog_en;
    assign sensor_reset = state.sensor_rst;
endmodule

/* hdl/scrc_frame_timer.sv */
`timescale 1ns/100ps
module scrc_frame_timer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic restart,
    input wire logic [scrc_pkg::HBLANK_W-1:0] hblank,
    // Timing
    output logic lv,
    output logic fv,
    output logic row_end,
    output logic frame_last
);
    import scrc_pkg::*;

    typedef struct packed {
        logic [COL_W-1:0] col;
        logic [ROW_W-1:0] row;
    } scrc_timer_s;

    scrc_timer_s state;
    scrc_timer_s next_state;
    logic [COL_W-1:0] len_m1;

    assign len_m1 = ACTIVE_COLS + COL_W'(hblank) - 12'h001;
    // Guard against a shorter row arriving mid-row
    assign row_end = run && !restart && (state.col >= len_m1);
    assign frame_last = row_end && (state.row == FRAME_ROWS - 11'h001);
    assign lv = run && (state.col < ACTIVE_COLS) && (state.row < ACTIVE_ROWS);
    assign fv = run && (state.row < ACTIVE_ROWS);

    // ------------------------------------------------------------
    // Column and row counters
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (restart) begin
            next_state = '0;
        end else if (run) begin
            if (row_end) begin
                next_state.col = '0;
                next_state.row = frame_last ? '0 : state.row + 11'h001;
            end else begin
                next_state.col = state.col + 12'h001;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule

/* hdl/scrc_pkg.sv */
package scrc_pkg;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } scrc_req_s;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_HBLANK = 8'h07;
    localparam logic [ADDR_W-1:0] ADDR_SHUTTER = 8'h09;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h0d;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int BIT_HOLD = 15;
    localparam int BIT_RESTART_BAD = 9;
    localparam int BIT_SHOW_BAD = 8;
    localparam int BIT_PROC_RESET = 5;
    localparam int BIT_OUT_DISABLE = 4;
    localparam int BIT_READOUT_EN = 3;
    localparam int BIT_STANDBY = 2;
    localparam int BIT_RESTART = 1;
    localparam int BIT_SOFT_RESET = 0;
    localparam logic [DATA_W-1:0] CTRL_MASK = 16'h833d;
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0008;

    // ------------------------------------------------------------
    // Frame synchronised settings
    // ------------------------------------------------------------
    localparam int HBLANK_W = 11;
    localparam int SHUTTER_W = 16;
    localparam logic [HBLANK_W-1:0] HBLANK_RESET = 11'h0be;
    localparam logic [HBLANK_W-1:0] HBLANK_MIN_FULL = 11'h0ca;
    localparam logic [HBLANK_W-1:0] HBLANK_MIN_LOW = 11'h072;
    localparam logic [SHUTTER_W-1:0] SHUTTER_RESET = 16'h0219;

    // ------------------------------------------------------------
    // Readout geometry
    // ------------------------------------------------------------
    localparam int COL_W = 12;
    localparam int ROW_W = 11;
    localparam logic [COL_W-1:0] ACTIVE_COLS = 12'h040;
    localparam logic [ROW_W-1:0] ACTIVE_ROWS = 11'h030;
    localparam logic [ROW_W-1:0] FRAME_ROWS = 11'h038;

    // ------------------------------------------------------------
    // Core state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] ctl;
        logic lp_meta;
        logic lp_sync;
        logic en_prev;
        logic restart_req;
        logic bad_cur;
        logic gate;
        logic [SHUTTER_W-1:0] integ;
        logic [DATA_W-1:0] rdata;
        logic fv;
        logic lv;
        logic oe;
        logic proc_rst;
        logic analog_en;
        logic sensor_rst;
    } scrc_core_s;

endpackage

/* hdl/scrc_shadow.sv */
`timescale 1ns/100ps
module scrc_shadow #(
    parameter int W = 16,
    parameter logic [W-1:0] RESET = '0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control
    input wire logic clr,
    input wire logic wr,
    input wire logic [W-1:0] wdata,
    input wire logic apply,
    // Values
    output logic [W-1:0] staged,
    output logic [W-1:0] active,
    output logic changed
);
    import scrc_pkg::*;

    typedef struct packed {
        logic [W-1:0] staged;
        logic [W-1:0] active;
        logic changed;
    } scrc_shadow_s;

    scrc_shadow_s state;
    scrc_shadow_s next_state;

    // ------------------------------------------------------------
    // Staging and frame boundary transfer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.changed = 1'b0;
        if (clr) begin
            next_state.staged = RESET;
            next_state.active = RESET;
        end else begin
            if (wr) begin
                next_state.staged = wdata;
            end
            if (apply) begin
                next_state.active = state.staged;
                next_state.changed = (state.staged != state.active);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '{staged: RESET, active: RESET, changed: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign staged = state.staged;
    assign active = state.active;
    assign changed = state.changed;
endmodule

/* sim/scrc_core_monitor.sv */
`timescale 1ns/100ps
module scrc_core_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire scrc_pkg::scrc_req_s bus_req,
    input wire logic [scrc_pkg::DATA_W-1:0] rdata,
    // Pins
    input wire logic low_power_mode,
    input wire logic fv_out,
    input wire logic lv_out,
    input wire logic video_oe,
    input wire logic proc_reset,
    input wire logic analog_en,
    input wire logic sensor_reset
);
    import scrc_pkg::*;
    // ------------------------------------------------------------
    // Control register mirror and its age since the last write
    // ------------------------------------------------------------
    logic [DATA_W-1:0] ctl_m;
    logic [2:0] age;
    logic ctl_wr;
    logic mapped;
    assign ctl_wr = bus_req.wr && bus_req.addr == ADDR_CTRL;
    assign mapped = bus_req.addr == ADDR_CTRL || bus_req.addr == ADDR_HBLANK || bus_req.addr == ADDR_SHUTTER;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_m <= CTRL_RESET;
            age <= 3'h7;
        end else if (ctl_wr) begin
            ctl_m <= bus_req.wdata & CTRL_MASK;
            age <= 3'h0;
        end else if (age != 3'h7) begin
            age <= age + 3'h1;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_rdata_idle: assert property (!bus_req.rd |=> rdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_ctrl_read: assert property (bus_req.rd && bus_req.addr == ADDR_CTRL |=> rdata == $past(ctl_m))
        else $error("control read back wrong");
    a_unmapped_read: assert property (bus_req.rd && !mapped |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_oe_follow: assert property (age >= 3'h2 |-> video_oe == !ctl_m[BIT_OUT_DISABLE])
        else $error("output enable wrong");
    a_proc_follow: assert property (age >= 3'h2 |-> proc_reset == ctl_m[BIT_PROC_RESET])
        else $error("processor reset wrong");
    a_analog_follow: assert property (age >= 3'h2 |-> analog_en == !ctl_m[BIT_STANDBY])
        else $error("analog enable wrong");
    a_sreset_follow: assert property (age >= 3'h2 |-> sensor_reset == ctl_m[BIT_SOFT_RESET])
        else $error("sensor reset wrong");
    a_soft_quiet: assert property (ctl_m[BIT_SOFT_RESET] && age == 3'h7 |-> !fv_out && !lv_out)
        else $error("video active in soft reset");
    a_stop_hold: assert property (!ctl_m[BIT_READOUT_EN] && age == 3'h7 |-> $stable(fv_out) && $stable(lv_out))
        else $error("video moved while stopped");
endmodule

bind scrc_core scrc_core_monitor scrc_core_monitor_inst (.ref_clk, .rst_n, .bus_req, .rdata, .low_power_mode,
    .fv_out, .lv_out, .video_oe, .proc_reset, .analog_en, .sensor_reset);

/* sim/scrc_core_tb.sv */
`timescale 1ns/100ps
module scrc_core_tb;
    import scrc_pkg::*;
    logic ref_clk;
    logic rst_n;
    scrc_req_s bus_req;
    logic low_power_mode;
    logic [DATA_W-1:0] rdata;
    logic fv_out, lv_out, video_oe, proc_reset, analog_en, sensor_reset;
    int num_errors = 0;
    int compares = 0;
    int n;

    scrc_core scrc_core_inst (.ref_clk, .rst_n, .bus_req, .rdata, .low_power_mode, .fv_out, .lv_out,
        .video_oe, .proc_reset, .analog_en, .sensor_reset);

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task close_out;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task fail(input string m);
        num_errors++;
        $display("ERROR %0t %s", $time, m);
    endtask
    task chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        compares++;
        if (got !== exp) fail($sformatf("value %h expected %h", got, exp));
    endtask
    task chk_n(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) fail($sformatf("count %0d outside %0d..%0d", got, lo, hi));
    endtask
    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge ref_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge ref_clk);
        bus_req <= '0;
    endtask
    task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge ref_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge ref_clk);
        bus_req <= '0;
        #1;
        chk(rdata, exp);
    endtask
    task wfv(input logic v);
        int t;
        for (t = 0; t < 60000 && fv_out !== v; t++) @(posedge ref_clk);
        if (fv_out !== v) begin
            fail("frame wait ran out");
            close_out();
        end
    endtask
    // Blank columns between two lines, skipping vertical blanking
    task gap(input int exp);
        int t, r, g;
        bit h;
        r = 0;
        h = 1'b0;
        g = 0;
        for (t = 0; t < 60000 && g == 0; t++) begin
            @(posedge ref_clk);
            if (lv_out === 1'b1) begin
                if (h && r > 0 && r < 1000) g = r;
                h = 1'b1;
                r = 0;
            end else begin
                r++;
            end
        end
        if (g == 0) begin
            fail("line wait ran out");
            close_out();
        end
        chk_n(g, exp, exp);
    endtask
    task lowrun(output int c);
        for (c = 0; c < 60000 && fv_out !== 1'b1; c++) @(posedge ref_clk);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        bus_req = '0;
        low_power_mode = 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_HBLANK, 16'h00be);
        rd(ADDR_SHUTTER, 16'h0219);
        wr(ADDR_CTRL, 16'hfffb);
        rd(ADDR_CTRL, 16'h8339);
        repeat (8) @(posedge ref_clk);
        chk({12'h000, video_oe, proc_reset, analog_en, sensor_reset}, 16'h0007);
        wr(ADDR_CTRL, CTRL_RESET);
        wr(8'h00, 16'hffff);
        rd(8'h00, 16'h0000);
        repeat (8) @(posedge ref_clk);
        chk({12'h000, video_oe, proc_reset, analog_en, sensor_reset}, 16'h000a);
        $display("test registers done");
        wr(ADDR_SHUTTER, 16'h0002);
        gap(202);
        low_power_mode <= 1'b1;
        gap(190);
        wr(ADDR_CTRL, 16'h8108);
        wr(ADDR_HBLANK, 16'h0010);
        wfv(1'b0);
        wfv(1'b1);
        gap(190);
        wr(ADDR_CTRL, 16'h0108);
        wfv(1'b0);
        wfv(1'b1);
        gap(114);
        low_power_mode <= 1'b0;
        gap(202);
        $display("test blanking done");
        wfv(1'b1);
        wr(ADDR_CTRL, CTRL_RESET);
        wr(ADDR_HBLANK, 16'h00be);
        wfv(1'b0);
        lowrun(n);
        chk_n(n, 11312, 59999);
        $display("test bad frame done");
        wfv(1'b1);
        wr(ADDR_CTRL, 16'h0208);
        wr(ADDR_HBLANK, 16'h00c8);
        wfv(1'b0);
        lowrun(n);
        chk_n(n, 2655, 2680);
        $display("test bad restart done");
        wfv(1'b1);
        wr(ADDR_CTRL, 16'h000a);
        repeat (3) @(posedge ref_clk);
        lowrun(n);
        chk_n(n, 530, 545);
        rd(ADDR_CTRL, CTRL_RESET);
        wfv(1'b1);
        wr(ADDR_CTRL, 16'h0004);
        repeat (50) @(posedge ref_clk);
        chk({15'h0000, analog_en}, 16'h0000);
        wr(ADDR_CTRL, CTRL_RESET);
        repeat (3) @(posedge ref_clk);
        lowrun(n);
        chk_n(n, 530, 545);
        $display("test restart done");
        close_out();
    end
endmodule
